/* File: include/lut_pkg.sv */
package lut_pkg;
  // Register byte offsets
  localparam logic [11:0] STATIC_FWD_OFF = 12'h424;
  localparam logic [11:0] STATIC_FID_MAC_HI_OFF = 12'h428;
  localparam logic [11:0] STATIC_MAC_LO_OFF = 12'h42c;
  localparam logic [11:0] TABLE_CTRL_OFF = 12'h430;
  localparam logic [11:0] LOOKUP_CTRL_OFF = 12'h434;
  localparam logic [11:0] VLAN_ENTRY0_OFF = 12'h440;
  localparam logic [11:0] VLAN_ENTRY1_OFF = 12'h444;
  localparam logic [11:0] VLAN_ENTRY2_OFF = 12'h448;
  localparam logic [11:0] VLAN_INDEX_OFF = 12'h44c;
  localparam logic [11:0] VLAN_ACCESS_OFF = 12'h450;
  // Forwarding / static entry fields
  localparam int BYPASS_BIT = 31;
  localparam int GID_MATCH_BIT = 30;
  localparam int FWD_W = 3;
  localparam int FID_LSB = 16;
  localparam int FID_W = 7;
  localparam int MAC_HI_W = 16;
  // Shared table control fields
  localparam int TBL_IDX_W = 6;
  localparam int TBL_SEL_BIT = 6;
  localparam int TBL_RD_BIT = 7;
  localparam int TBL_GO_BIT = 8;
  // Lookup control and VLAN access fields
  localparam int VLAN_MODE_BIT = 0;
  localparam int VLAN_RD_BIT = 0;
  localparam int VLAN_GO_BIT = 7;
  // VLAN entry 0 fields
  localparam int VE_VALID_BIT = 0;
  localparam int VE_FWDOPT_BIT = 1;
  localparam int VE_PRIO_LSB = 2;
  localparam int VE_STG_LSB = 5;
  localparam int VE_FID_LSB = 8;
  localparam int PRIO_W = 3;
  localparam int MASK_W = 7;
  localparam logic [6:0] PORT_MASK_USED = 7'h07;
  // Table sizes
  localparam int STATIC_DEPTH = 16;
  localparam int STATIC_W = 60;
  localparam logic [5:0] MCAST_ADDRS = 6'h30;
  localparam int MCAST_GROUPS = 8;
  localparam int VLAN_DEPTH = 4096;
  localparam int VLAN_IDX_W = 12;
  localparam int VLAN_W = 29;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Fixed grouping of the reserved multicast addresses
  function automatic logic [2:0] mcast_group(input logic [5:0] idx);
    logic [2:0] g;
    g = 3'h7;
    case (idx)
      6'h00: g = 3'h0;
      6'h01: g = 3'h1;
      6'h02: g = 3'h2;
      6'h10: g = 3'h3;
      6'h20: g = 3'h4;
      6'h21: g = 3'h5;
      default:
      begin
        if (idx > 6'h21)
          g = 3'h6;
      end
    endcase
    return g;
  endfunction
endpackage

/* File: src/mcast_group_table.sv */
`timescale 1ns/1ps
module mcast_group_table (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access port
  input wire logic wr_en,
  input wire logic [5:0] idx,
  input wire logic [2:0] wr_data,
  output logic [2:0] rd_data,
  // Lookup port
  input wire logic [5:0] lookup_addr,
  output logic [2:0] lookup_fwd
);
  logic [2:0] grp_r [0:lut_pkg::MCAST_GROUPS-1];
  logic [2:0] wg;

  assign wg = lut_pkg::mcast_group(idx);
  // Addresses past the last reserved one read as no ports
  assign rd_data = (idx < lut_pkg::MCAST_ADDRS) ? grp_r[wg] : 3'h0;

  // One slot per group, so a write reaches every address of the group
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < lut_pkg::MCAST_GROUPS; i++)
        grp_r[i] <= 3'h0;
    end
    else if (wr_en && idx < lut_pkg::MCAST_ADDRS)
      grp_r[wg] <= wr_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lookup_fwd <= 3'h0;
    else if (lookup_addr < lut_pkg::MCAST_ADDRS)
      lookup_fwd <= grp_r[lut_pkg::mcast_group(lookup_addr)];
    else
      lookup_fwd <= 3'h0;
  end

  a_group_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx < lut_pkg::MCAST_ADDRS) |=> grp_r[$past(wg)] == $past(wr_data))
    else $error("multicast group slot not updated");
endmodule

/* File: src/vlan_table.sv */
`timescale 1ns/1ps
module vlan_table (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access port
  input wire logic wr_en,
  input wire logic [11:0] idx,
  input wire logic [28:0] wr_data,
  output logic [28:0] rd_data,
  // Lookup port
  input wire logic [11:0] lookup_vid,
  output logic [28:0] lookup_data
);
  // Contents are undefined until software fills the table
  logic [28:0] mem_r [0:lut_pkg::VLAN_DEPTH-1];

  always_ff @(posedge pclk)
  begin
    if (wr_en)
      mem_r[idx] <= wr_data;
  end

  assign rd_data = mem_r[idx];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lookup_data <= 29'h0;
    else
      lookup_data <= mem_r[lookup_vid];
  end
endmodule

/* File: src/switch_lookup_table_access.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Bit 31 enables port state port_state_bypass
// - Bit 30 compares group id on multicast
// - Low three forward bits select ports 1-3
// - Group id, MAC high, MAC low layout
// - Multicast table indexed by six address bits
// - Write changes whole fixed group, one of eight groups
// - Table select one reaches multicast table
// - Direction bit zero writes, one reads
// - Go flag self-clears when operation finishes
// - Multicast read presents mask in forward register
// - VLAN mode uses 4096-entry table per packet
// - VLAN entry has one-bit valid flag
// - Forward option selects membership mask forwarding
// - Three-bit priority and spanning tree group
// - Seven-bit filter id for hashing
// - Untag mask, port 1 at LSB
// - Membership mask, port 1 at LSB
// - Twelve-bit VLAN index equals VID
// - VLAN access bit 7 self-clears
// - Static table sixteen entries, four-bit index
// - Table select zero reaches static table
// - VLAN read fills three data registers
module switch_lookup_table_access (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Static table lookup
  input wire logic [3:0] static_lookup_idx,
  output logic static_port_state_bypass,
  output logic static_multicast_group_id_match,
  output logic [2:0] static_fwd_ports,
  output logic [6:0] static_filter_group_id,
  output logic [47:0] static_mac,
  // Reserved multicast lookup
  input wire logic [5:0] mcast_lookup_addr,
  output logic [2:0] mcast_fwd_ports,
  // VLAN lookup
  input wire logic [11:0] vlan_lookup_vid,
  output logic vlan_lookup_active,
  output logic vlan_fwd_option,
  output logic [2:0] vlan_priority,
  output logic [2:0] vlan_spanning_tree_group,
  output logic [6:0] vlan_filter_group_id,
  output logic [6:0] vlan_untag_mask,
  output logic [6:0] vlan_member_mask
);
  logic acc_wr;
  logic setup;
  logic mapped;
  logic [31:0] rd_mux;
  // Data registers
  logic bypass_r;
  logic gid_match_r;
  logic [2:0] fwd_r;
  logic [6:0] fid_r;
  logic [15:0] mac_hi_r;
  logic [31:0] mac_lo_r;
  // Shared table control
  logic [5:0] tbl_idx_r;
  logic tbl_sel_r;
  logic tbl_rd_r;
  logic static_go_r;
  logic vlan_mode_r;
  // VLAN registers
  logic ve_valid_r;
  logic ve_fwdopt_r;
  logic [2:0] ve_prio_r;
  logic [2:0] ve_stg_r;
  logic [6:0] ve_fid_r;
  logic [6:0] ve_untag_r;
  logic [6:0] ve_member_r;
  logic [11:0] vlan_idx_r;
  logic vlan_rd_r;
  logic vlan_go_r;
  // Table operations
  logic st_wr;
  logic st_rd;
  logic mc_wr;
  logic mc_rd;
  logic vt_wr;
  logic vt_rd;
  logic [2:0] mc_rd_data;
  logic [28:0] vt_rd_data;
  logic [28:0] vt_wr_data;
  logic [28:0] vt_lookup;
  logic [59:0] st_mem [0:lut_pkg::STATIC_DEPTH-1];
  logic [59:0] st_rd_data;

  assign acc_wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = psel && penable;

  // Operations run in the cycle after the go flag is written
  assign st_wr = static_go_r && !tbl_rd_r && !tbl_sel_r;
  assign st_rd = static_go_r && tbl_rd_r && !tbl_sel_r;
  assign mc_wr = static_go_r && !tbl_rd_r && tbl_sel_r;
  assign mc_rd = static_go_r && tbl_rd_r && tbl_sel_r;
  assign vt_wr = vlan_go_r && !vlan_rd_r;
  assign vt_rd = vlan_go_r && vlan_rd_r;
  assign st_rd_data = st_mem[tbl_idx_r[3:0]];

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = lut_pkg::REG_RESET;
    case (paddr)
      lut_pkg::STATIC_FWD_OFF:
      begin
        rd_mux[lut_pkg::BYPASS_BIT] = bypass_r;
        rd_mux[lut_pkg::GID_MATCH_BIT] = gid_match_r;
        rd_mux[lut_pkg::FWD_W-1:0] = fwd_r;
      end
      lut_pkg::STATIC_FID_MAC_HI_OFF:
      begin
        rd_mux[lut_pkg::FID_LSB +: lut_pkg::FID_W] = fid_r;
        rd_mux[lut_pkg::MAC_HI_W-1:0] = mac_hi_r;
      end
      lut_pkg::STATIC_MAC_LO_OFF: rd_mux = mac_lo_r;
      lut_pkg::TABLE_CTRL_OFF:
      begin
        rd_mux[lut_pkg::TBL_IDX_W-1:0] = tbl_idx_r;
        rd_mux[lut_pkg::TBL_SEL_BIT] = tbl_sel_r;
        rd_mux[lut_pkg::TBL_RD_BIT] = tbl_rd_r;
        rd_mux[lut_pkg::TBL_GO_BIT] = static_go_r;
      end
      lut_pkg::LOOKUP_CTRL_OFF: rd_mux[lut_pkg::VLAN_MODE_BIT] = vlan_mode_r;
      lut_pkg::VLAN_ENTRY0_OFF:
      begin
        rd_mux[lut_pkg::VE_VALID_BIT] = ve_valid_r;
        rd_mux[lut_pkg::VE_FWDOPT_BIT] = ve_fwdopt_r;
        rd_mux[lut_pkg::VE_PRIO_LSB +: lut_pkg::PRIO_W] = ve_prio_r;
        rd_mux[lut_pkg::VE_STG_LSB +: lut_pkg::PRIO_W] = ve_stg_r;
        rd_mux[lut_pkg::VE_FID_LSB +: lut_pkg::FID_W] = ve_fid_r;
      end
      lut_pkg::VLAN_ENTRY1_OFF: rd_mux[lut_pkg::MASK_W-1:0] = ve_untag_r;
      lut_pkg::VLAN_ENTRY2_OFF: rd_mux[lut_pkg::MASK_W-1:0] = ve_member_r;
      lut_pkg::VLAN_INDEX_OFF: rd_mux[lut_pkg::VLAN_IDX_W-1:0] = vlan_idx_r;
      lut_pkg::VLAN_ACCESS_OFF:
      begin
        rd_mux[lut_pkg::VLAN_GO_BIT] = vlan_go_r;
        rd_mux[lut_pkg::VLAN_RD_BIT] = vlan_rd_r;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= lut_pkg::REG_RESET;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? lut_pkg::REG_RESET : rd_mux;
      pslverr <= !mapped;
    end
  end

  // Forward/control register, shared by static and multicast tables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bypass_r <= 1'b0;
      gid_match_r <= 1'b0;
      fwd_r <= 3'h0;
    end
    else if (st_rd)
    begin
      bypass_r <= st_rd_data[59];
      gid_match_r <= st_rd_data[58];
      fwd_r <= st_rd_data[57:55];
    end
    else if (mc_rd)
      fwd_r <= mc_rd_data;
    else if (acc_wr && paddr == lut_pkg::STATIC_FWD_OFF)
    begin
      bypass_r <= pwdata[lut_pkg::BYPASS_BIT];
      gid_match_r <= pwdata[lut_pkg::GID_MATCH_BIT];
      fwd_r <= pwdata[lut_pkg::FWD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fid_r <= 7'h00;
      mac_hi_r <= 16'h0000;
      mac_lo_r <= lut_pkg::REG_RESET;
    end
    else if (st_rd)
    begin
      fid_r <= st_rd_data[54:48];
      mac_hi_r <= st_rd_data[47:32];
      mac_lo_r <= st_rd_data[31:0];
    end
    else if (acc_wr && paddr == lut_pkg::STATIC_FID_MAC_HI_OFF)
    begin
      fid_r <= pwdata[lut_pkg::FID_LSB +: lut_pkg::FID_W];
      mac_hi_r <= pwdata[lut_pkg::MAC_HI_W-1:0];
    end
    else if (acc_wr && paddr == lut_pkg::STATIC_MAC_LO_OFF)
      mac_lo_r <= pwdata;
  end

  // Static entries hold what software wrote; no aging touches them
  always_ff @(posedge pclk)
  begin
    if (st_wr)
      st_mem[tbl_idx_r[3:0]] <= {bypass_r, gid_match_r, fwd_r, fid_r, mac_hi_r, mac_lo_r};
  end

  // Shared control register; a new go wins over the self-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbl_idx_r <= 6'h00;
      tbl_sel_r <= 1'b0;
      tbl_rd_r <= 1'b0;
      static_go_r <= 1'b0;
    end
    else if (acc_wr && paddr == lut_pkg::TABLE_CTRL_OFF)
    begin
      tbl_idx_r <= pwdata[lut_pkg::TBL_IDX_W-1:0];
      tbl_sel_r <= pwdata[lut_pkg::TBL_SEL_BIT];
      tbl_rd_r <= pwdata[lut_pkg::TBL_RD_BIT];
      static_go_r <= pwdata[lut_pkg::TBL_GO_BIT] | static_go_r;
    end
    else if (static_go_r)
      static_go_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vlan_mode_r <= 1'b0;
    else if (acc_wr && paddr == lut_pkg::LOOKUP_CTRL_OFF)
      vlan_mode_r <= pwdata[lut_pkg::VLAN_MODE_BIT];
  end

  // VLAN data registers; reserved port bits read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ve_valid_r <= 1'b0;
      ve_fwdopt_r <= 1'b0;
      ve_prio_r <= 3'h0;
      ve_stg_r <= 3'h0;
      ve_fid_r <= 7'h00;
      ve_untag_r <= 7'h00;
      ve_member_r <= 7'h00;
    end
    else if (vt_rd)
    begin
      {ve_member_r, ve_untag_r, ve_fid_r, ve_stg_r, ve_prio_r} <= vt_rd_data[28:2];
      ve_fwdopt_r <= vt_rd_data[1];
      ve_valid_r <= vt_rd_data[0];
    end
    else if (acc_wr && paddr == lut_pkg::VLAN_ENTRY0_OFF)
    begin
      ve_valid_r <= pwdata[lut_pkg::VE_VALID_BIT];
      ve_fwdopt_r <= pwdata[lut_pkg::VE_FWDOPT_BIT];
      ve_prio_r <= pwdata[lut_pkg::VE_PRIO_LSB +: lut_pkg::PRIO_W];
      ve_stg_r <= pwdata[lut_pkg::VE_STG_LSB +: lut_pkg::PRIO_W];
      ve_fid_r <= pwdata[lut_pkg::VE_FID_LSB +: lut_pkg::FID_W];
    end
    else if (acc_wr && paddr == lut_pkg::VLAN_ENTRY1_OFF)
      ve_untag_r <= pwdata[lut_pkg::MASK_W-1:0] & lut_pkg::PORT_MASK_USED;
    else if (acc_wr && paddr == lut_pkg::VLAN_ENTRY2_OFF)
      ve_member_r <= pwdata[lut_pkg::MASK_W-1:0] & lut_pkg::PORT_MASK_USED;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vlan_idx_r <= 12'h000;
    else if (acc_wr && paddr == lut_pkg::VLAN_INDEX_OFF)
      vlan_idx_r <= pwdata[lut_pkg::VLAN_IDX_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vlan_rd_r <= 1'b0;
      vlan_go_r <= 1'b0;
    end
    else if (acc_wr && paddr == lut_pkg::VLAN_ACCESS_OFF)
    begin
      vlan_rd_r <= pwdata[lut_pkg::VLAN_RD_BIT];
      vlan_go_r <= pwdata[lut_pkg::VLAN_GO_BIT] | vlan_go_r;
    end
    else if (vlan_go_r)
      vlan_go_r <= 1'b0;
  end

  assign vt_wr_data = {ve_member_r, ve_untag_r, ve_fid_r, ve_stg_r, ve_prio_r, ve_fwdopt_r,
                       ve_valid_r};

  mcast_group_table u_mcast (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mc_wr),
    .idx(tbl_idx_r),
    .wr_data(fwd_r),
    .rd_data(mc_rd_data),
    .lookup_addr(mcast_lookup_addr),
    .lookup_fwd(mcast_fwd_ports)
  );

  vlan_table u_vlan (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(vt_wr),
    .idx(vlan_idx_r),
    .wr_data(vt_wr_data),
    .rd_data(vt_rd_data),
    .lookup_vid(vlan_lookup_vid),
    .lookup_data(vt_lookup)
  );

  // Static lookup: one cycle from index to fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      static_port_state_bypass <= 1'b0;
      static_multicast_group_id_match <= 1'b0;
      static_fwd_ports <= 3'h0;
      static_filter_group_id <= 7'h00;
      static_mac <= 48'h0;
    end
    else
    begin
      static_port_state_bypass <= st_mem[static_lookup_idx][59];
      static_multicast_group_id_match <= st_mem[static_lookup_idx][58];
      static_fwd_ports <= st_mem[static_lookup_idx][57:55];
      static_filter_group_id <= st_mem[static_lookup_idx][54:48];
      static_mac <= st_mem[static_lookup_idx][47:0];
    end
  end

  // Garbage in an unfilled table is harmless while the mode is off
  assign vlan_lookup_active = vlan_mode_r && vt_lookup[0];
  assign vlan_fwd_option = vt_lookup[1];
  assign vlan_priority = vt_lookup[4:2];
  assign vlan_spanning_tree_group = vt_lookup[7:5];
  assign vlan_filter_group_id = vt_lookup[14:8];
  assign vlan_untag_mask = vt_lookup[21:15];
  assign vlan_member_mask = vt_lookup[28:22];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_static_go_clear: assert property (static_go_r && !acc_wr |=> !static_go_r)
    else $error("table go flag did not self-clear");
  a_vlan_go_clear: assert property (vlan_go_r && !acc_wr |=> !vlan_go_r)
    else $error("vlan go flag did not self-clear");
  a_bypass_write: assert property (acc_wr && paddr == lut_pkg::STATIC_FWD_OFF && !static_go_r
    |=> bypass_r == $past(pwdata[31]))
    else $error("port_state_bypass bit not stored");
  a_gid_write: assert property (acc_wr && paddr == lut_pkg::STATIC_FWD_OFF && !static_go_r
    |=> gid_match_r == $past(pwdata[30]))
    else $error("group id match bit not stored");
  a_static_readback: assert property ((st_wr && !acc_wr) ##1 (!acc_wr && !static_go_r)[*2]
    |-> st_rd_data[57:55] == $past(fwd_r, 2))
    else $error("static entry ports not written");
  a_mcast_range: assert property (mc_rd && tbl_idx_r >= lut_pkg::MCAST_ADDRS
    |=> fwd_r == 3'h0)
    else $error("out of range multicast index gave ports");
  a_mcast_read: assert property (mc_rd |=> fwd_r == $past(mc_rd_data))
    else $error("multicast read did not load forward register");
  a_vlan_read: assert property (vt_rd |=> ve_fid_r == $past(vt_rd_data[14:8])
    && ve_member_r == $past(vt_rd_data[28:22]))
    else $error("vlan read did not load data registers");
  a_vlan_masks: assert property (ve_untag_r[6:3] == 4'h0 && ve_member_r[6:3] == 4'h0)
    else $error("reserved vlan port bits set");
  a_vlan_active: assert property (!vlan_mode_r |-> !vlan_lookup_active)
    else $error("vlan lookup active with mode off");

  c_static_write: cover property (st_wr);
  c_mcast_read: cover property (mc_wr ##[1:20] mc_rd);
  c_vlan_rw: cover property (vt_wr ##[1:20] vt_rd);
endmodule

/* File: tb/switch_lookup_table_access_tb.sv */
`timescale 1ns/1ps
module switch_lookup_table_access_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] static_lookup_idx;
  logic static_port_state_bypass;
  logic static_multicast_group_id_match;
  logic [2:0] static_fwd_ports;
  logic [6:0] static_filter_group_id;
  logic [47:0] static_mac;
  logic [5:0] mcast_lookup_addr;
  logic [2:0] mcast_fwd_ports;
  logic [11:0] vlan_lookup_vid;
  logic vlan_lookup_active;
  logic vlan_fwd_option;
  logic [2:0] vlan_priority;
  logic [2:0] vlan_spanning_tree_group;
  logic [6:0] vlan_filter_group_id;
  logic [6:0] vlan_untag_mask;
  logic [6:0] vlan_member_mask;
  logic [31:0] rd;
  logic err;
  int n_mismatch;
  int compares;

  switch_lookup_table_access i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .static_lookup_idx(static_lookup_idx),
    .static_port_state_bypass(static_port_state_bypass),
    .static_multicast_group_id_match(static_multicast_group_id_match),
    .static_fwd_ports(static_fwd_ports), .static_filter_group_id(static_filter_group_id),
    .static_mac(static_mac), .mcast_lookup_addr(mcast_lookup_addr),
    .mcast_fwd_ports(mcast_fwd_ports), .vlan_lookup_vid(vlan_lookup_vid),
    .vlan_lookup_active(vlan_lookup_active), .vlan_fwd_option(vlan_fwd_option),
    .vlan_priority(vlan_priority), .vlan_spanning_tree_group(vlan_spanning_tree_group),
    .vlan_filter_group_id(vlan_filter_group_id), .vlan_untag_mask(vlan_untag_mask),
    .vlan_member_mask(vlan_member_mask)
  );

  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 16)
    begin
      n_mismatch++;
      $display("BAD %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0);
    check({16'h0, rd}, {16'h0, exp}, what);
  endtask

  // Poll a go flag; it must clear within a few polls
  task automatic wait_clear(input logic [11:0] a, input int b);
    int n;
    n = 0;
    apb(1'h0, a, 32'h0);
    while (rd[b] !== 1'h0 && n < 4)
    begin
      n++;
      apb(1'h0, a, 32'h0);
    end
    check({47'h0, rd[b]}, 48'h0, "go flag clear");
  endtask

  task automatic t_reset();
    rdchk(lut_pkg::STATIC_FWD_OFF, lut_pkg::REG_RESET, "fwd reset");
    rdchk(lut_pkg::STATIC_FID_MAC_HI_OFF, lut_pkg::REG_RESET, "fid reset");
    rdchk(lut_pkg::STATIC_MAC_LO_OFF, lut_pkg::REG_RESET, "mac lo reset");
    rdchk(lut_pkg::TABLE_CTRL_OFF, lut_pkg::REG_RESET, "ctrl reset");
    rdchk(lut_pkg::VLAN_ACCESS_OFF, lut_pkg::REG_RESET, "vlan access reset");
    wr(12'h500, 32'hffffffff);
    check({47'h0, err}, 48'h1, "unmapped write error");
    rdchk(12'h500, 32'h0, "unmapped read data");
    check({47'h0, err}, 48'h1, "unmapped read error");
    $display("test reset done");
  endtask

  task automatic t_static();
    logic [31:0] f [2];
    logic [31:0] h [2];
    logic [31:0] l [2];
    logic [3:0] ix [2];
    f = '{32'h80000001, 32'h40000006};
    h = '{32'h002a1234, 32'h00550abc};
    l = '{32'hdeadbeef, 32'h01234567};
    ix = '{4'h0, 4'hf};
    // Reserved bits must read back as zero
    wr(lut_pkg::STATIC_FWD_OFF, 32'hffffffff);
    rdchk(lut_pkg::STATIC_FWD_OFF, 32'hc0000007, "fwd reserved");
    wr(lut_pkg::STATIC_FID_MAC_HI_OFF, 32'hffffffff);
    rdchk(lut_pkg::STATIC_FID_MAC_HI_OFF, 32'h007fffff, "fid reserved");
    for (int i = 0; i < 2; i++)
    begin
      wr(lut_pkg::STATIC_FWD_OFF, f[i]);
      wr(lut_pkg::STATIC_FID_MAC_HI_OFF, h[i]);
      wr(lut_pkg::STATIC_MAC_LO_OFF, l[i]);
      wr(lut_pkg::TABLE_CTRL_OFF, {23'h0, 9'h100} | {28'h0, ix[i]});
      wait_clear(lut_pkg::TABLE_CTRL_OFF, lut_pkg::TBL_GO_BIT);
    end
    for (int i = 0; i < 2; i++)
    begin
      static_lookup_idx <= ix[i];
      repeat (2) @(posedge pclk);
      check({47'h0, static_port_state_bypass}, {47'h0, f[i][31]}, "bypass");
      check({47'h0, static_multicast_group_id_match}, {47'h0, f[i][30]}, "gid");
      check({45'h0, static_fwd_ports}, {45'h0, f[i][2:0]}, "ports");
      check({41'h0, static_filter_group_id}, {41'h0, h[i][22:16]}, "fid");
      check(static_mac, {h[i][15:0], l[i]}, "mac");
      wr(lut_pkg::STATIC_FWD_OFF, 32'h0);
      wr(lut_pkg::STATIC_FID_MAC_HI_OFF, 32'h0);
      wr(lut_pkg::STATIC_MAC_LO_OFF, 32'h0);
      wr(lut_pkg::TABLE_CTRL_OFF, {23'h0, 9'h180} | {28'h0, ix[i]});
      wait_clear(lut_pkg::TABLE_CTRL_OFF, lut_pkg::TBL_GO_BIT);
      rdchk(lut_pkg::STATIC_FWD_OFF, f[i], "read fwd");
      rdchk(lut_pkg::STATIC_FID_MAC_HI_OFF, h[i], "read fid");
      rdchk(lut_pkg::STATIC_MAC_LO_OFF, l[i], "read mac");
    end
    $display("test static done");
  endtask

  task automatic mc_op(input logic [31:0] mask, input logic [31:0] ctrl);
    wr(lut_pkg::STATIC_FWD_OFF, mask);
    wr(lut_pkg::TABLE_CTRL_OFF, ctrl);
    wait_clear(lut_pkg::TABLE_CTRL_OFF, lut_pkg::TBL_GO_BIT);
  endtask

  task automatic mc_look(input logic [5:0] a, input logic [2:0] exp);
    mcast_lookup_addr <= a;
    repeat (2) @(posedge pclk);
    check({45'h0, mcast_fwd_ports}, {45'h0, exp}, "mcast ports");
  endtask

  task automatic t_mcast();
    mc_op(32'h5, 32'h00000162);
    mc_op(32'h3, 32'h00000140);
    // Index past the 48 addresses must be ignored
    mc_op(32'h7, 32'h00000170);
    mc_look(6'h2f, 3'h5);
    mc_look(6'h22, 3'h5);
    mc_look(6'h00, 3'h3);
    mc_look(6'h01, 3'h0);
    mc_look(6'h30, 3'h0);
    // A read past the 48 addresses must return no ports
    mc_op(32'h7, 32'h000001f0);
    rdchk(lut_pkg::STATIC_FWD_OFF, 32'h0, "mcast read out of range");
    mc_op(32'hc0000000, 32'h000001e5);
    rdchk(lut_pkg::STATIC_FWD_OFF, 32'hc0000005, "mcast read mask");
    $display("test mcast done");
  endtask

  task automatic t_vlan();
    wr(lut_pkg::VLAN_ENTRY0_OFF, 32'h0);
    wr(lut_pkg::VLAN_ENTRY2_OFF, 32'h2);
    wr(lut_pkg::VLAN_INDEX_OFF, 32'h0);
    wr(lut_pkg::VLAN_ACCESS_OFF, 32'h80);
    wait_clear(lut_pkg::VLAN_ACCESS_OFF, lut_pkg::VLAN_GO_BIT);
    wr(lut_pkg::VLAN_ENTRY0_OFF, 32'h00005a77);
    wr(lut_pkg::VLAN_ENTRY1_OFF, 32'h0000007f);
    wr(lut_pkg::VLAN_ENTRY2_OFF, 32'h00000005);
    wr(lut_pkg::VLAN_INDEX_OFF, 32'h00000fff);
    wr(lut_pkg::VLAN_ACCESS_OFF, 32'h80);
    wait_clear(lut_pkg::VLAN_ACCESS_OFF, lut_pkg::VLAN_GO_BIT);
    // Table is filled before lookup mode is turned on
    wr(lut_pkg::LOOKUP_CTRL_OFF, 32'h1);
    vlan_lookup_vid <= 12'hfff;
    repeat (2) @(posedge pclk);
    check({47'h0, vlan_lookup_active}, 48'h1, "vlan active");
    check({47'h0, vlan_fwd_option}, 48'h1, "fwd option");
    check({45'h0, vlan_priority}, 48'h5, "priority");
    check({45'h0, vlan_spanning_tree_group}, 48'h3, "stg");
    check({41'h0, vlan_filter_group_id}, 48'h5a, "vlan fid");
    check({41'h0, vlan_untag_mask}, 48'h7, "untag");
    check({41'h0, vlan_member_mask}, 48'h5, "member");
    vlan_lookup_vid <= 12'h000;
    repeat (2) @(posedge pclk);
    check({47'h0, vlan_lookup_active}, 48'h0, "invalid entry");
    check({41'h0, vlan_member_mask}, 48'h2, "member idx0");
    wr(lut_pkg::LOOKUP_CTRL_OFF, 32'h0);
    vlan_lookup_vid <= 12'hfff;
    repeat (2) @(posedge pclk);
    check({47'h0, vlan_lookup_active}, 48'h0, "mode off");
    wr(lut_pkg::VLAN_ENTRY0_OFF, 32'h0);
    wr(lut_pkg::VLAN_ENTRY1_OFF, 32'h0);
    wr(lut_pkg::VLAN_ENTRY2_OFF, 32'h0);
    wr(lut_pkg::VLAN_ACCESS_OFF, 32'h81);
    wait_clear(lut_pkg::VLAN_ACCESS_OFF, lut_pkg::VLAN_GO_BIT);
    rdchk(lut_pkg::VLAN_ENTRY0_OFF, 32'h00005a77, "read entry0");
    rdchk(lut_pkg::VLAN_ENTRY1_OFF, 32'h00000007, "read untag");
    rdchk(lut_pkg::VLAN_ENTRY2_OFF, 32'h00000005, "read member");
    $display("test vlan done");
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    n_mismatch = 0;
    compares = 0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    static_lookup_idx = 4'h0;
    mcast_lookup_addr = 6'h0;
    vlan_lookup_vid = 12'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_static();
    t_mcast();
    t_vlan();
    tally_and_finish();
  end
endmodule
